// File: rtl/sod_detect.v
`timescale 1ns/10ps
`include "sod_defs.vh"

// Summary of operation
// R1: Power-on reset clears offset and both control registers, sets power-on flag.
// R2: Host initialises every other register and loads only valid time data.
// R3: Detected oscillation stop clears the running flag until host writes one.
// R4: Writing one to the running flag arms the stop detector and sets it.
// R5: Writing zero to running flag or one to low-voltage flag does nothing.
// R6: Supply drop below selected threshold sets and holds the low-voltage flag.
// R7: Threshold select bit, default zero: zero picks 2.1 V, one picks 1.3 V.
// R8: Once low-voltage flag is one, monitoring stops and the flag holds.
// R9: Writing zero to the low-voltage flag clears it and restarts monitoring.
// R10: Monitor samples for 7.8 ms of every one-second period while active.
// R11: Status flags sit at bits 4, 5 and 6 of the second control register.
// R12: Host decides reinitialisation, normal or weak supply from the three flags.
// R13: Writing zero clears the power-on flag; writing one does nothing.
// R14: While power-on flag is one, registers other than the oscillation flag stay cleared and interrupt pins float.
// R15: Oscillation stop and comparator events are synchronised before use.
module sod_detect #(
  parameter [31:0] MON_PERIOD_CYCLES = `SOD_MON_PERIOD_CYCLES,
  parameter [31:0] MON_SAMPLE_CYCLES = `SOD_MON_SAMPLE_CYCLES
) (
  // Clock and power-on reset
  input  wire       i_clock,
  input  wire       i_rst_n,
  // Register port from the serial bus engine
  input  wire       i_wr_en,
  input  wire       i_rd_en,
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wr_data,
  output reg  [7:0] o_rd_data,
  // Analog detectors
  input  wire       i_osc_stop,
  input  wire       i_supply_low,
  output reg        o_threshold_select,
  output reg        o_monitor_enable,
  // Interrupt requests and open-drain pins
  input  wire       i_irq_a_req,
  input  wire       i_irq_b_req,
  output reg        o_irq_out_a,
  output reg        o_irq_out_a_oe_n,
  output reg        o_irq_out_b,
  output reg        o_irq_out_b_oe_n,
  // Register contents for the rest of the clock
  output reg  [7:0] o_offset_trim,
  output reg  [7:0] o_alarm_ctrl
);

  reg  [7:0]  offset_trim_reg;
  reg  [7:0]  alarm_ctrl_reg;
  reg         thresh_sel_reg;
  reg         low_voltage_flag_reg;
  reg         osc_running_flag_reg;
  reg         power_on_flag_reg;
  reg  [3:0]  ctrl_low_reg;
  reg         osc_armed_reg;
  reg  [31:0] period_cnt_reg;
  wire        osc_stop_sync;
  wire        supply_low_sync;
  wire        wr_detect;
  wire        wr_trim;
  wire        wr_alarm;
  wire [7:0]  detect_ctrl;
  reg  [7:0]  rd_data_next;

  // Register select; shared by the write strobes and the read mux.
  function addr_hit;
    input [3:0] addr;
    input [3:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  sod_sync u_sync_osc (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async (i_osc_stop),
    .o_level (osc_stop_sync)
  ); // R15

  sod_sync u_sync_supply (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async (i_supply_low),
    .o_level (supply_low_sync)
  ); // R15

  assign wr_trim     = i_wr_en && addr_hit(i_addr, `SOD_ADDR_OFFSET_TRIM);
  assign wr_alarm    = i_wr_en && addr_hit(i_addr, `SOD_ADDR_ALARM_CTRL);
  assign wr_detect   = i_wr_en && addr_hit(i_addr, `SOD_ADDR_DETECT_CTRL);
  assign detect_ctrl = {thresh_sel_reg, low_voltage_flag_reg, osc_running_flag_reg,
                        power_on_flag_reg, ctrl_low_reg}; // R11

  // Plain register bits; a pending power-on flag keeps them cleared.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      offset_trim_reg <= `SOD_RST_OFFSET_TRIM; // R1
      alarm_ctrl_reg  <= `SOD_RST_ALARM_CTRL; // R1
      thresh_sel_reg  <= `SOD_RST_THRESH_SEL; // R7
      ctrl_low_reg    <= `SOD_RST_DETECT_LOW; // R1
    end else if (power_on_flag_reg) begin
      offset_trim_reg <= `SOD_RST_OFFSET_TRIM; // R14
      alarm_ctrl_reg  <= `SOD_RST_ALARM_CTRL; // R14
      thresh_sel_reg  <= `SOD_RST_THRESH_SEL; // R14
      ctrl_low_reg    <= `SOD_RST_DETECT_LOW; // R14
    end else if (i_wr_en) begin
      if (wr_trim) begin
        offset_trim_reg <= i_wr_data & `SOD_OFFSET_TRIM_MASK;
      end
      if (wr_alarm) begin
        alarm_ctrl_reg <= i_wr_data;
      end
      if (wr_detect) begin
        thresh_sel_reg <= i_wr_data[`SOD_BIT_THRESH_SEL]; // R7
        ctrl_low_reg   <= i_wr_data[3:0];
      end
    end
  end

  // Power-on flag: set only by reset, cleared only by writing zero.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      power_on_flag_reg <= `SOD_RST_POWER_ON; // R1
    end else if (wr_detect && !i_wr_data[`SOD_BIT_POWER_ON]) begin
      power_on_flag_reg <= 1'b0; // R13
    end
  end

  // Oscillation flag. Once armed by an earlier write, a stop seen in the cycle of an arming write still wins,
  // so a real stop is never hidden by software.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_running_flag_reg <= `SOD_RST_OSC_RUNNING; // R1
      osc_armed_reg        <= 1'b0;
    end else begin
      if (wr_detect && i_wr_data[`SOD_BIT_OSC_RUNNING]) begin
        osc_armed_reg <= 1'b1; // R4
      end
      if (osc_armed_reg && osc_stop_sync) begin
        osc_running_flag_reg <= 1'b0; // R3
      end else if (wr_detect && i_wr_data[`SOD_BIT_OSC_RUNNING]) begin
        osc_running_flag_reg <= 1'b1; // R4 R5
      end
    end
  end

  // Low-voltage flag. A drop wins over a clearing write in the same cycle.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_voltage_flag_reg <= `SOD_RST_LOW_VOLTAGE; // R1
    end else if (power_on_flag_reg) begin
      low_voltage_flag_reg <= `SOD_RST_LOW_VOLTAGE; // R14
    end else if (o_monitor_enable && supply_low_sync) begin
      low_voltage_flag_reg <= 1'b1; // R6 R8
    end else if (wr_detect && !i_wr_data[`SOD_BIT_LOW_VOLTAGE]) begin
      low_voltage_flag_reg <= 1'b0; // R9 R5
    end
  end

  // One-second time base; the comparator only draws current in the window.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      period_cnt_reg   <= 32'h00000000;
      o_monitor_enable <= 1'b0;
    end else begin
      if (period_cnt_reg == MON_PERIOD_CYCLES - 32'h00000001) begin
        period_cnt_reg <= 32'h00000000;
      end else begin
        period_cnt_reg <= period_cnt_reg + 32'h00000001;
      end
      o_monitor_enable <= !low_voltage_flag_reg && (period_cnt_reg < MON_SAMPLE_CYCLES); // R10 R8
    end
  end

  // Read mux; read data holds between reads and unmapped offsets read zero.
  always @* begin
    rd_data_next = o_rd_data;
    if (i_rd_en) begin
      rd_data_next = 8'h00;
      if (addr_hit(i_addr, `SOD_ADDR_OFFSET_TRIM)) begin
        rd_data_next = offset_trim_reg;
      end
      if (addr_hit(i_addr, `SOD_ADDR_ALARM_CTRL)) begin
        rd_data_next = alarm_ctrl_reg;
      end
      if (addr_hit(i_addr, `SOD_ADDR_DETECT_CTRL)) begin
        rd_data_next = detect_ctrl; // R11
      end
    end
  end

  // Read data and register copies, all registered.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data          <= 8'h00;
      o_threshold_select <= `SOD_RST_THRESH_SEL;
      o_offset_trim      <= `SOD_RST_OFFSET_TRIM;
      o_alarm_ctrl       <= `SOD_RST_ALARM_CTRL;
    end else begin
      o_rd_data          <= rd_data_next;
      o_threshold_select <= thresh_sel_reg; // R7
      o_offset_trim      <= offset_trim_reg;
      o_alarm_ctrl       <= alarm_ctrl_reg;
    end
  end

  // Interrupt pins are open drain: data stays low and only the enable moves.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_out_a      <= 1'b0;
      o_irq_out_a_oe_n <= 1'b1;
      o_irq_out_b      <= 1'b0;
      o_irq_out_b_oe_n <= 1'b1;
    end else begin
      o_irq_out_a      <= 1'b0;
      o_irq_out_a_oe_n <= !(i_irq_a_req && !power_on_flag_reg); // R14
      o_irq_out_b      <= 1'b0;
      o_irq_out_b_oe_n <= !(i_irq_b_req && !power_on_flag_reg); // R14
    end
  end

endmodule

// File: rtl/sod_defs.vh
`ifndef SOD_DEFS_VH
`define SOD_DEFS_VH

// Register offsets on the register port.
`define SOD_ADDR_OFFSET_TRIM   4'h7
`define SOD_ADDR_ALARM_CTRL    4'hE
`define SOD_ADDR_DETECT_CTRL   4'hF

// Field positions in detect_status_control.
`define SOD_BIT_THRESH_SEL     7
`define SOD_BIT_LOW_VOLTAGE    6
`define SOD_BIT_OSC_RUNNING    5
`define SOD_BIT_POWER_ON       4

// Reset values and the offset trim write mask.
`define SOD_RST_OFFSET_TRIM    8'h00
`define SOD_RST_ALARM_CTRL     8'h00
`define SOD_RST_DETECT_LOW     4'h0
`define SOD_RST_THRESH_SEL     1'b0
`define SOD_RST_LOW_VOLTAGE    1'b0
`define SOD_RST_OSC_RUNNING    1'b0
`define SOD_RST_POWER_ON       1'b1
`define SOD_OFFSET_TRIM_MASK   8'h7F

// Timing of the voltage monitor.
`define SOD_CLOCK_MHZ          250
`define SOD_MON_PERIOD_MS      1000
`define SOD_MON_SAMPLE_US      7800
`define SOD_MON_PERIOD_CYCLES  (`SOD_MON_PERIOD_MS * 1000 * `SOD_CLOCK_MHZ)
`define SOD_MON_SAMPLE_CYCLES  (`SOD_MON_SAMPLE_US * `SOD_CLOCK_MHZ)

`endif

// File: rtl/sod_sync.v
`timescale 1ns/10ps
// Three-stage synchroniser; the output follows once stages two and three agree.
module sod_sync (
  // Clock and reset
  input  wire i_clock,
  input  wire i_rst_n,
  // Asynchronous level in, clean level out
  input  wire i_async,
  output reg  o_level
);

  reg sync1_reg;
  reg sync2_reg;
  reg sync3_reg;

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      o_level   <= 1'b0;
    end else begin
      sync1_reg <= i_async;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        o_level <= sync3_reg;
      end
    end
  end

endmodule

// File: test/sod_detect_sva.sv
`timescale 1ns/10ps
module sod_detect_sva #(
  parameter [31:0] MON_PERIOD_CYCLES = 32'h64,
  parameter [31:0] MON_SAMPLE_CYCLES = 32'h4
) (
  // Watched ports of the detector.
  input wire       i_clock,
  input wire       i_rst_n,
  input wire       i_wr_en,
  input wire       i_rd_en,
  input wire [3:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire [7:0] o_rd_data,
  input wire       i_osc_stop,
  input wire       i_supply_low,
  input wire       o_threshold_select,
  input wire       o_monitor_enable,
  input wire       i_irq_a_req,
  input wire       i_irq_b_req,
  input wire       o_irq_out_a,
  input wire       o_irq_out_a_oe_n,
  input wire       o_irq_out_b,
  input wire       o_irq_out_b_oe_n,
  input wire [7:0] o_offset_trim,
  input wire [7:0] o_alarm_ctrl
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Counting catches a window that never closes, which a fixed delay would miss.
  reg [31:0] high_cnt;
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) high_cnt <= 32'h0;
    else high_cnt <= o_monitor_enable ? high_cnt + 32'h1 : 32'h0;
  end
  a_mon_window: assert property (high_cnt <= MON_SAMPLE_CYCLES) else $error("window too long");
  a_mon_gap: assert property ($fell(o_monitor_enable) |-> !o_monitor_enable [*8]) else $error("window gap");
  a_trim_copy: assert property ($changed(o_offset_trim) |-> $past(i_wr_en && i_addr == 4'h7, 2))
    else $error("trim changed");
  a_ctrl_copy: assert property ($changed(o_alarm_ctrl) |-> $past(i_wr_en && i_addr == 4'hE, 2))
    else $error("ctrl changed");
  a_rd_hold: assert property (!i_rd_en |=> $stable(o_rd_data)) else $error("read data moved");
  a_irq_float_a: assert property (!i_irq_a_req |=> o_irq_out_a_oe_n) else $error("pin a driven");
  a_irq_float_b: assert property (!i_irq_b_req |=> o_irq_out_b_oe_n) else $error("pin b driven");
  a_irq_data: assert property (!o_irq_out_a && !o_irq_out_b) else $error("pin data high");
endmodule
bind sod_detect sod_detect_sva #(
  .MON_PERIOD_CYCLES (MON_PERIOD_CYCLES),
  .MON_SAMPLE_CYCLES (MON_SAMPLE_CYCLES)
) u_sva (
  .i_clock            (i_clock),
  .i_rst_n            (i_rst_n),
  .i_wr_en            (i_wr_en),
  .i_rd_en            (i_rd_en),
  .i_addr             (i_addr),
  .i_wr_data          (i_wr_data),
  .o_rd_data          (o_rd_data),
  .i_osc_stop         (i_osc_stop),
  .i_supply_low       (i_supply_low),
  .o_threshold_select (o_threshold_select),
  .o_monitor_enable   (o_monitor_enable),
  .i_irq_a_req        (i_irq_a_req),
  .i_irq_b_req        (i_irq_b_req),
  .o_irq_out_a        (o_irq_out_a),
  .o_irq_out_a_oe_n   (o_irq_out_a_oe_n),
  .o_irq_out_b        (o_irq_out_b),
  .o_irq_out_b_oe_n   (o_irq_out_b_oe_n),
  .o_offset_trim      (o_offset_trim),
  .o_alarm_ctrl       (o_alarm_ctrl)
);

// File: test/sod_host.sv
`timescale 1ns/10ps
module sod_host (
  // Clock.
  input  wire       i_clock,
  // Register port.
  output reg        o_wr_en = 1'b0,
  output reg        o_rd_en = 1'b0,
  output reg  [3:0] o_addr = 4'h0,
  output reg  [7:0] o_wr_data = 8'h00,
  input  wire [7:0] i_rd_data
);
  // Released lines show the inverse, so a stale value is never mistaken for a live one.
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(negedge i_clock);
      o_wr_en = 1'b1;
      o_addr = a;
      o_wr_data = d;
      @(negedge i_clock);
      o_wr_en = 1'b0;
      o_addr = ~a;
      o_wr_data = ~d;
    end
  endtask
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(negedge i_clock);
      o_rd_en = 1'b1;
      o_addr = a;
      @(negedge i_clock);
      o_rd_en = 1'b0;
      o_addr = ~a;
      d = i_rd_data;
    end
  endtask
endmodule

// File: test/sod_detect_tb.sv
`timescale 1ns/10ps
module sod_detect_tb;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_osc_stop = 1'b0;
  logic        i_supply_low = 1'b0;
  logic        i_irq_a_req = 1'b1;
  logic        i_irq_b_req = 1'b0;
  logic [7:0]  got;
  logic [20:0] rows [0:8];
  integer      mismatches = 0;
  integer      cmp_count = 0;
  integer      i;
  wire         i_wr_en, i_rd_en, o_threshold_select, o_monitor_enable;
  wire         o_irq_out_a, o_irq_out_a_oe_n, o_irq_out_b, o_irq_out_b_oe_n;
  wire [3:0]   i_addr;
  wire [7:0]   i_wr_data, o_rd_data, o_offset_trim, o_alarm_ctrl;
  always #2 i_clock = ~i_clock;
  sod_host host (.i_clock(i_clock), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr),
    .o_wr_data(i_wr_data), .i_rd_data(o_rd_data));
  sod_detect #(.MON_PERIOD_CYCLES(32'h64), .MON_SAMPLE_CYCLES(32'h4)) uut (
    .i_clock            (i_clock),
    .i_rst_n            (i_rst_n),
    .i_wr_en            (i_wr_en),
    .i_rd_en            (i_rd_en),
    .i_addr             (i_addr),
    .i_wr_data          (i_wr_data),
    .o_rd_data          (o_rd_data),
    .i_osc_stop         (i_osc_stop),
    .i_supply_low       (i_supply_low),
    .o_threshold_select (o_threshold_select),
    .o_monitor_enable   (o_monitor_enable),
    .i_irq_a_req        (i_irq_a_req),
    .i_irq_b_req        (i_irq_b_req),
    .o_irq_out_a        (o_irq_out_a),
    .o_irq_out_a_oe_n   (o_irq_out_a_oe_n),
    .o_irq_out_b        (o_irq_out_b),
    .o_irq_out_b_oe_n   (o_irq_out_b_oe_n),
    .o_offset_trim      (o_offset_trim),
    .o_alarm_ctrl       (o_alarm_ctrl)
  );
  task chk(input [63:0] name, input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("Error %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task rdc(input [3:0] a, input [7:0] e);
    begin
      host.rd(a, got);
      chk("read", got, e);
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    rows[0] = {1'b0, 4'hF, 8'h00, 8'h10};
    rows[1] = {1'b1, 4'h7, 8'hFF, 8'h00};
    rows[2] = {1'b1, 4'hF, 8'h00, 8'h00};
    rows[3] = {1'b1, 4'h7, 8'hFF, 8'h7F};
    rows[4] = {1'b1, 4'hE, 8'hA5, 8'hA5};
    rows[5] = {1'b1, 4'hF, 8'hA0, 8'hA0};
    rows[6] = {1'b1, 4'hF, 8'hC0, 8'hA0};
    rows[7] = {1'b1, 4'hF, 8'h10, 8'h20};
    rows[8] = {1'b0, 4'h3, 8'h00, 8'h00};
    repeat (5) @(negedge i_clock);
    i_rst_n = 1'b1;
    chk("oe_n", {7'h00, o_irq_out_a_oe_n}, 8'h01);
    for (i = 0; i < 9; i = i + 1) begin
      if (rows[i][20]) host.wr(rows[i][19:16], rows[i][15:8]);
      rdc(rows[i][19:16], rows[i][7:0]);
    end
    chk("oe_n", {7'h00, o_irq_out_a_oe_n}, 8'h00);
    chk("trim", o_offset_trim, 8'h7F);
    chk("alarm", o_alarm_ctrl, 8'hA5);
    i_irq_b_req = 1'b1;
    repeat (2) @(negedge i_clock);
    chk("oe_n_b", {7'h00, o_irq_out_b_oe_n}, 8'h00);
    chk("pins", {6'h00, o_irq_out_a, o_irq_out_b}, 8'h00);
    $display("register rows done");
    host.wr(4'hF, 8'hA0);
    @(negedge i_clock);
    chk("thresh", {7'h00, o_threshold_select}, 8'h01);
    i_supply_low = 1'b1;
    repeat (120) @(negedge i_clock);
    chk("monitor", {7'h00, o_monitor_enable}, 8'h00);
    i_supply_low = 1'b0;
    rdc(4'hF, 8'hE0);
    host.wr(4'hF, 8'hA0);
    rdc(4'hF, 8'hA0);
    i_osc_stop = 1'b1;
    repeat (8) @(negedge i_clock);
    i_osc_stop = 1'b0;
    repeat (8) @(negedge i_clock);
    rdc(4'hF, 8'h80);
    host.wr(4'hF, 8'hA0);
    rdc(4'hF, 8'hA0);
    i_irq_a_req = 1'b0;
    repeat (2) @(negedge i_clock);
    chk("oe_n", {7'h00, o_irq_out_a_oe_n}, 8'h01);
    $display("detector events done");
    i_rst_n = 1'b0;
    repeat (5) @(negedge i_clock);
    i_rst_n = 1'b1;
    rdc(4'hF, 8'h10);
    rdc(4'hE, 8'h00);
    chk("trim", o_offset_trim, 8'h00);
    chk("oe_n_b", {7'h00, o_irq_out_b_oe_n}, 8'h01);
    i_supply_low = 1'b1;
    repeat (120) @(negedge i_clock);
    i_supply_low = 1'b0;
    rdc(4'hF, 8'h10);
    $display("second reset done");
    end_of_test;
  end
  // Well beyond the expected run length of under two microseconds.
  initial begin
    #20000;
    mismatches = mismatches + 1;
    end_of_test;
  end
endmodule
